/* File: design/tag_state_machine.sv */
`timescale 1ns/1ps
module tag_state_machine
  import tag_state_pkg::*;
(
  input  wire logic          i_mclk,          // System clock, 50 MHz.
  input  wire logic          i_rst,           // Synchronous reset, high.
  input  wire logic          i_power_ok,      // Field/buffer sustains operation.
  input  wire logic          i_cmd_valid,     // One-cycle completed command.
  input  wire tag_cmd_type   i_cmd,           // Command identifier.
  input  wire cmp_type       i_cmp,           // Compare result of group data.
  input  wire logic          i_flag_set,      // Addressed flag is set.
  input  wire logic          i_id_match,      // Carried ID matches own ID.
  input  wire logic          i_write_done,    // Pulse: write or lock succeeded.
  output tag_state_type      o_state,         // Current tag state.
  output logic               o_write_ok,      // Last-write-succeeded flag.
  output logic               o_cmd_active,    // Pulse: command was active.
  output logic               o_respond        // Pulse: respond to command.
);

  typedef struct packed {
    tag_state_type state;
    logic          write_ok;
    logic          active;
    logic          respond;
  } regs_type;

  regs_type r_q, r_d;

  function automatic logic cond_true(input tag_cmd_type c, input cmp_type p,
                                     input logic f);
    begin
      case (c)
        CMD_GSEL_EQ, CMD_GUNSEL_EQ:             cond_true = (p == CMP_EQ);
        CMD_GSEL_NE, CMD_GUNSEL_NE:             cond_true = (p != CMP_EQ);
        CMD_GSEL_GT, CMD_GUNSEL_GT:             cond_true = (p == CMP_GT);
        CMD_GSEL_LT, CMD_GUNSEL_LT:             cond_true = (p == CMP_LT);
        CMD_GSEL_EQ_FLAGS, CMD_GUNSEL_EQ_FLAGS: cond_true = f;
        CMD_GSEL_NE_FLAGS, CMD_GUNSEL_NE_FLAGS: cond_true = !f;
        default:                                cond_true = 1'b0;
      endcase
    end
  endfunction : cond_true

  function automatic logic is_gsel(input tag_cmd_type c);
    is_gsel = (c inside {CMD_GSEL_EQ, CMD_GSEL_NE, CMD_GSEL_GT, CMD_GSEL_LT,
                         CMD_GSEL_EQ_FLAGS, CMD_GSEL_NE_FLAGS});
  endfunction : is_gsel

  function automatic logic is_addr(input tag_cmd_type c);
    is_addr = (c inside {CMD_READ, CMD_WRITE, CMD_WRITE4, CMD_QUERY_LOCK,
                         CMD_READ_FLAGS, CMD_READ_VARIABLE, CMD_READ_PORT});
  endfunction : is_addr

  always_comb begin
    logic act;
    act = 1'b0;
    r_d = r_q;
    r_d.state = r_q.state;
    if (i_write_done) begin
      r_d.write_ok = 1'b1;
    end
    if (i_cmd_valid) begin
      case (r_q.state)
        ST_READY: begin
          if (is_gsel(i_cmd)) begin
            act = 1'b1;
            if (cond_true(i_cmd, i_cmp, i_flag_set)) begin
              r_d.state = ST_ID;
            end
          end else if (is_addr(i_cmd)) begin
            act = 1'b1;
            if (i_id_match) begin
              r_d.state = ST_DATA_EX;
            end
          end else if (i_cmd == CMD_READ_VERIFY ||
                       i_cmd == CMD_READ_VERIFY4) begin
            act = 1'b1;
            if (i_id_match && r_q.write_ok) begin
              r_d.state = ST_DATA_EX;
            end
          end else if (i_cmd == CMD_READ_UNADDR) begin
            act = 1'b1;
            r_d.state = ST_DATA_EX;
          end else if (i_cmd == CMD_INITIALIZE) begin
            act = 1'b1;
            r_d.state = ST_READY;
          end
        end
        ST_ID: begin
          act = 1'b1;
          if (is_gsel(i_cmd)) begin
            r_d.state = ST_ID;
          end else if (i_cmd inside {CMD_GUNSEL_EQ, CMD_GUNSEL_NE,
                       CMD_GUNSEL_GT, CMD_GUNSEL_LT, CMD_GUNSEL_EQ_FLAGS,
                       CMD_GUNSEL_NE_FLAGS}) begin
            if (cond_true(i_cmd, i_cmp, i_flag_set)) begin
              r_d.state = ST_READY;
            end
          end else if (i_cmd == CMD_MULTI_UNSEL) begin
            if (i_cmp == CMP_EQ && r_q.write_ok) begin
              r_d.state = ST_READY;
            end
          end else if (i_cmd == CMD_INITIALIZE) begin
            r_d.state = ST_READY;
          end else if (is_addr(i_cmd) || i_cmd == CMD_DATA_READ ||
                       i_cmd == CMD_DATA_READ_O) begin
            if (i_id_match) begin
              r_d.state = ST_DATA_EX;
            end
          end else if (i_cmd == CMD_READ_VERIFY ||
                       i_cmd == CMD_READ_VERIFY4) begin
            if (i_id_match && r_q.write_ok) begin
              r_d.state = ST_DATA_EX;
            end
          end else if (i_cmd == CMD_READ_UNADDR) begin
            r_d.state = ST_DATA_EX;
          end else if (i_cmd inside {CMD_FAIL, CMD_SUCCESS, CMD_RESEND,
                       CMD_FAIL_O, CMD_SUCCESS_O, CMD_RESEND_O,
                       CMD_WRITE_MULTI, CMD_WRITE4_MULTI}) begin
            r_d.state = ST_ID;
          end else begin
            act = 1'b0;
          end
        end
        ST_DATA_EX: begin
          if (i_cmd == CMD_INITIALIZE) begin
            act = 1'b1;
            r_d.state = ST_READY;
          end else if (i_cmd inside {CMD_READ, CMD_DATA_READ,
                       CMD_READ_VERIFY, CMD_READ_VERIFY4, CMD_WRITE,
                       CMD_WRITE4, CMD_WRITE4_MULTI, CMD_WRITE_MULTI,
                       CMD_LOCK, CMD_QUERY_LOCK, CMD_READ_UNADDR,
                       CMD_DATA_READ_O, CMD_READ_FLAGS, CMD_READ_VARIABLE,
                       CMD_READ_PORT}) begin
            act = 1'b1;
            r_d.state = ST_DATA_EX;
          end
        end
        default: begin
          act = 1'b0;
        end
      endcase
      // Clearing only on an active command keeps the flag for the verify
      // that follows a write; a new write in the same cycle wins.
      if (act && !i_write_done) begin
        r_d.write_ok = 1'b0;
      end
    end
    r_d.active  = act;
    r_d.respond = act;
    if (r_q.state == ST_POWER_OFF && i_power_ok) begin
      r_d.state   = ST_READY;
    end
    if (!i_power_ok) begin
      r_d.state    = ST_POWER_OFF;
      r_d.write_ok = 1'b0;
      r_d.active   = 1'b0;
      r_d.respond  = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      r_q <= '{state: RST_STATE, write_ok: RST_WRITE_OK,
               active: 1'b0, respond: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  assign o_state      = r_q.state;
  assign o_write_ok   = r_q.write_ok;
  assign o_cmd_active = r_q.active;
  assign o_respond    = r_q.respond;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_off_silent: assert property (
    o_state == ST_POWER_OFF && i_cmd_valid
    |=> !o_respond && !o_cmd_active && o_state != ST_ID &&
        o_state != ST_DATA_EX)
    else $error("command acted while powered off");
  a_off_ignores: assert property (
    o_state == ST_POWER_OFF && !i_power_ok |=> o_state == ST_POWER_OFF)
    else $error("left power off without field");
  a_power_up: assert property (
    o_state == ST_POWER_OFF && i_power_ok |=> o_state == ST_READY)
    else $error("power up did not reach READY");
  a_init_ready: assert property (
    i_power_ok && i_cmd_valid && i_cmd == CMD_INITIALIZE &&
    o_state != ST_POWER_OFF |=> o_state == ST_READY)
    else $error("INITIALIZE did not give READY");
  a_unaddr_read: assert property (
    i_power_ok && i_cmd_valid && i_cmd == CMD_READ_UNADDR &&
    o_state inside {ST_READY, ST_ID} |=> o_state == ST_DATA_EX)
    else $error("unaddressed read missed DATA_EXCHANGE");
  a_verify_gate: assert property (
    i_power_ok && i_cmd_valid && i_cmd == CMD_READ_VERIFY &&
    o_state == ST_READY && !o_write_ok |=> o_state == ST_READY)
    else $error("verify without write flag moved");
  a_id_gsel: assert property (
    i_power_ok && i_cmd_valid && is_gsel(i_cmd) && o_state == ST_ID
    |=> o_state == ST_ID)
    else $error("group select left ID");
  a_field_loss: assert property (
    !i_power_ok |=> o_state == ST_POWER_OFF && !o_respond)
    else $error("field loss not handled");
  a_write_flag: assert property (
    i_write_done && i_power_ok |=> o_write_ok)
    else $error("write flag not set");
  a_lock_ready: assert property (
    i_power_ok && i_cmd_valid && i_cmd == CMD_LOCK && o_state == ST_READY
    |=> o_state == ST_READY && !o_respond)
    else $error("inactive command acted");

  c_select: cover property (o_state == ST_READY ##1 o_state == ST_ID);
  c_data_ex: cover property (o_state == ST_ID ##1 o_state == ST_DATA_EX);
  c_init: cover property (o_state == ST_DATA_EX ##1 o_state == ST_READY);
  c_drop: cover property (o_state == ST_ID ##1 o_state == ST_POWER_OFF);

endmodule : tag_state_machine

/* File: inc/tag_state_pkg.sv */
package tag_state_pkg;

  typedef enum logic [1:0] {
    ST_POWER_OFF = 2'b00,
    ST_READY     = 2'b01,
    ST_ID        = 2'b10,
    ST_DATA_EX   = 2'b11
  } tag_state_type;

  // Command identifiers presented by the frame decoder; values are internal.
  typedef enum logic [5:0] {
    CMD_GSEL_EQ        = 6'h00,
    CMD_GSEL_NE        = 6'h01,
    CMD_GSEL_GT        = 6'h02,
    CMD_GSEL_LT        = 6'h03,
    CMD_GSEL_EQ_FLAGS  = 6'h04,
    CMD_GSEL_NE_FLAGS  = 6'h05,
    CMD_GUNSEL_EQ      = 6'h06,
    CMD_GUNSEL_NE      = 6'h07,
    CMD_GUNSEL_GT      = 6'h08,
    CMD_GUNSEL_LT      = 6'h09,
    CMD_GUNSEL_EQ_FLAGS = 6'h0a,
    CMD_GUNSEL_NE_FLAGS = 6'h0b,
    CMD_MULTI_UNSEL    = 6'h0c,
    CMD_FAIL           = 6'h0d,
    CMD_SUCCESS        = 6'h0e,
    CMD_RESEND         = 6'h0f,
    CMD_INITIALIZE     = 6'h10,
    CMD_READ           = 6'h11,
    CMD_DATA_READ      = 6'h12,
    CMD_READ_VERIFY    = 6'h13,
    CMD_READ_VERIFY4   = 6'h14,
    CMD_WRITE          = 6'h15,
    CMD_WRITE4         = 6'h16,
    CMD_WRITE4_MULTI   = 6'h17,
    CMD_WRITE_MULTI    = 6'h18,
    CMD_LOCK           = 6'h19,
    CMD_QUERY_LOCK     = 6'h1a,
    CMD_FAIL_O         = 6'h1b,
    CMD_SUCCESS_O      = 6'h1c,
    CMD_DATA_READ_O    = 6'h1d,
    CMD_READ_FLAGS     = 6'h1e,
    CMD_READ_VARIABLE  = 6'h1f,
    CMD_READ_PORT      = 6'h20,
    CMD_READ_UNADDR    = 6'h21,
    CMD_RESEND_O       = 6'h22
  } tag_cmd_type;

  // Compare outcome of group commands.
  typedef enum logic [1:0] {
    CMP_EQ = 2'b00,
    CMP_GT = 2'b01,
    CMP_LT = 2'b10
  } cmp_type;

  localparam tag_state_type RST_STATE    = ST_POWER_OFF;
  localparam logic          RST_WRITE_OK = 1'b0;

endpackage : tag_state_pkg

/* File: verif/rfid_reader_model.sv */
`timescale 1ns/1ps
// Stands in for the interrogator and its frame decoder: each call delivers
// one complete command with its compare and match results.
module rfid_reader_model
  import tag_state_pkg::*;
(
  input  wire logic   i_mclk,      // Tag clock.
  output tag_cmd_type o_cmd,       // Command identifier.
  output cmp_type     o_cmp,       // Group compare result.
  output logic        o_flag_set,  // Addressed flag state.
  output logic        o_id_match,  // Carried ID matches.
  output logic        o_cmd_valid  // One-cycle command strobe.
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd       = CMD_FAIL;
    o_cmp       = CMP_EQ;
    o_flag_set  = 1'b0;
    o_id_match  = 1'b0;
  end

  // Called at a falling edge. Qualifiers are inverted once the strobe drops,
  // so a tag that samples them late cannot see a stale match.
  task send(input tag_cmd_type c, input logic [2:0] cf, input logic m);
    o_cmd       = c;
    o_cmp       = cmp_type'(cf[1:0]);
    o_flag_set  = cf[2];
    o_id_match  = m;
    o_cmd_valid = 1'b1;
    @(negedge i_mclk);
    o_cmd_valid = 1'b0;
    o_cmd       = tag_cmd_type'(~c);
    o_cmp       = cmp_type'(~cf[1:0]);
    o_flag_set  = ~cf[2];
    o_id_match  = ~m;
  endtask : send
endmodule : rfid_reader_model

/* File: verif/rfid_tag_state_machine_tb_top.sv */
`timescale 1ns/1ps
module rfid_tag_state_machine_tb_top
  import tag_state_pkg::*;
;
  localparam tag_state_type O = ST_POWER_OFF, R = ST_READY;
  localparam tag_state_type I = ST_ID, X = ST_DATA_EX;
  localparam logic          N = 1'b0, Y = 1'b1;
  localparam logic [2:0]    Z = 3'h0;
  logic          i_mclk, i_rst, i_power_ok, i_write_done;
  logic          cv, fs, im, o_write_ok, o_cmd_active, o_respond;
  tag_cmd_type   cmd;
  cmp_type       cr;
  tag_state_type o_state;
  int            mismatches = 0, n_tests = 0;
  // Per group variant {flag, compare}: first list meets the condition.
  logic [2:0]  tv [6] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h5, 3'h1};
  logic [2:0]  fv [6] = '{3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4};
  tag_cmd_type ad [7] = '{CMD_READ, CMD_WRITE, CMD_WRITE4, CMD_QUERY_LOCK,
    CMD_READ_FLAGS, CMD_READ_VARIABLE, CMD_READ_PORT};
  tag_cmd_type ia [8] = '{CMD_FAIL, CMD_SUCCESS, CMD_RESEND, CMD_FAIL_O,
    CMD_SUCCESS_O, CMD_RESEND_O, CMD_WRITE_MULTI, CMD_WRITE4_MULTI};
  tag_cmd_type dx [15] = '{CMD_READ, CMD_DATA_READ, CMD_READ_VERIFY,
    CMD_READ_VERIFY4, CMD_WRITE, CMD_WRITE4, CMD_WRITE4_MULTI,
    CMD_WRITE_MULTI, CMD_LOCK, CMD_QUERY_LOCK, CMD_READ_UNADDR,
    CMD_DATA_READ_O, CMD_READ_FLAGS, CMD_READ_VARIABLE, CMD_READ_PORT};

  rfid_reader_model rdr (.i_mclk(i_mclk), .o_cmd(cmd), .o_cmp(cr),
    .o_flag_set(fs), .o_id_match(im), .o_cmd_valid(cv));
  tag_state_machine dut (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_power_ok(i_power_ok), .i_cmd_valid(cv), .i_cmd(cmd), .i_cmp(cr),
    .i_flag_set(fs), .i_id_match(im), .i_write_done(i_write_done),
    .o_state(o_state), .o_write_ok(o_write_ok),
    .o_cmd_active(o_cmd_active), .o_respond(o_respond));

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task check(input logic [3:0] g, input logic [3:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : check

  // A power cycle returns to ST_READY from any state, ST_POWER_OFF included.
  task go(input tag_state_type s);
    @(negedge i_mclk) i_power_ok = N;
    @(negedge i_mclk) i_power_ok = Y;
    @(negedge i_mclk);
    if (s == I) rdr.send(CMD_GSEL_EQ, Z, N);
    if (s == X) rdr.send(CMD_READ_UNADDR, Z, N);
  endtask : go

  task chk(input tag_state_type f, input tag_cmd_type c,
           input logic [2:0] cf, input logic m, input logic w,
           input tag_state_type e, input logic r);
    go(f);
    if (w) begin
      i_write_done = Y;
      @(negedge i_mclk) i_write_done = N;
      check({o_state, o_write_ok, 1'b0}, {f, 2'b10});
    end else @(negedge i_mclk);
    rdr.send(c, cf, m);
    check({o_state, o_cmd_active, o_respond}, {e, r, r});
  endtask : chk

  task t_power;
    rdr.send(CMD_INITIALIZE, Z, Y);
    check({o_state, o_respond, 1'b0}, {O, 2'b00});
    @(negedge i_mclk);
    // A command that arrives with the field is lost; power-up still wins.
    i_power_ok = Y;
    rdr.send(CMD_READ_UNADDR, Z, Y);
    check({o_state, o_respond, o_cmd_active}, {R, 2'b00});
    @(negedge i_mclk);
    check({o_state, 2'b00}, {R, 2'b00});
    chk(X, CMD_READ, Z, N, Y, X, Y);
    go(X);
    i_write_done = Y;
    @(negedge i_mclk) i_power_ok = N;
    i_write_done = N;
    @(negedge i_mclk);
    check({o_state, o_write_ok, 1'b0}, {O, 2'b00});
    $display("test power done");
  endtask : t_power

  task t_group;
    for (int k = 0; k < 6; k++) begin
      chk(R, tag_cmd_type'(CMD_GSEL_EQ + k), tv[k], N, N, I, Y);
      chk(R, tag_cmd_type'(CMD_GSEL_EQ + k), fv[k], N, N, R, Y);
      chk(I, tag_cmd_type'(CMD_GSEL_EQ + k), tv[k], N, N, I, Y);
      chk(I, tag_cmd_type'(CMD_GUNSEL_EQ + k), tv[k], N, N, R, Y);
      chk(I, tag_cmd_type'(CMD_GUNSEL_EQ + k), fv[k], N, N, I, Y);
    end
    $display("test group done");
  endtask : t_group

  task t_multi;
    chk(I, CMD_MULTI_UNSEL, Z, N, Y, R, Y);
    check({3'h0, o_write_ok}, 4'h0);
    chk(I, CMD_MULTI_UNSEL, Z, N, N, I, Y);
    chk(I, CMD_MULTI_UNSEL, 3'h2, N, Y, I, Y);
    // A write that completes with an active command must keep the flag set.
    go(X);
    i_write_done = Y;
    rdr.send(CMD_WRITE, Z, Y);
    i_write_done = N;
    check({o_state, o_write_ok, o_respond}, {X, 2'b11});
    $display("test multi done");
  endtask : t_multi

  task t_addr;
    tag_cmd_type c;
    foreach (ad[k]) begin
      chk(R, ad[k], Z, Y, N, X, Y);
      chk(R, ad[k], Z, N, N, R, Y);
      chk(I, ad[k], Z, Y, N, X, Y);
      chk(I, ad[k], Z, N, N, I, Y);
    end
    for (int k = 0; k < 2; k++) begin
      c = k ? CMD_READ_VERIFY4 : CMD_READ_VERIFY;
      chk(R, c, Z, Y, Y, X, Y);
      chk(I, c, Z, Y, N, I, Y);
      chk(R, c, Z, N, Y, R, Y);
      c = k ? CMD_DATA_READ_O : CMD_DATA_READ;
      chk(I, c, Z, Y, N, X, Y);
      chk(I, c, Z, N, N, I, Y);
      chk(R, c, Z, Y, N, R, N);
    end
    chk(R, CMD_READ_UNADDR, Z, N, N, X, Y);
    chk(I, CMD_READ_UNADDR, Z, N, N, X, Y);
    $display("test addressed done");
  endtask : t_addr

  task t_dx;
    foreach (dx[k]) chk(X, dx[k], Z, N, N, X, Y);
    foreach (ia[k]) chk(I, ia[k], Z, Y, N, I, Y);
    chk(R, CMD_INITIALIZE, Z, N, N, R, Y);
    chk(I, CMD_INITIALIZE, Z, N, N, R, Y);
    chk(X, CMD_INITIALIZE, Z, N, N, R, Y);
    chk(R, CMD_GUNSEL_EQ, Z, N, N, R, N);
    chk(R, CMD_LOCK, Z, Y, N, R, N);
    chk(X, CMD_GSEL_EQ, Z, N, N, X, N);
    chk(X, CMD_FAIL, Z, N, N, X, N);
    $display("test exchange done");
  endtask : t_dx

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge i_mclk);
    mismatches++;
    report_and_stop;
  end

  initial begin
    i_rst = 1'b1;
    i_power_ok = N;
    i_write_done = N;
    // Count rising edges: the clock's first step from unknown to low must
    // not shorten the reset.
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'b0;
    t_power;
    t_group;
    t_multi;
    t_addr;
    t_dx;
    report_and_stop;
  end
endmodule : rfid_tag_state_machine_tb_top
